// file: rtl/watchdog_refresh_reset.sv
// refresh watchdog driving the controller reset
// How it works
// - power-on or undervoltage reset initialises timer
// - refresh reloads timer; reload starts at max
// - every reset restores maximum reload, clears timer
// - count after reset released, refresh low
// - timeout before refresh edge gives reset pulse
// - long first pulse programs timer and reload
// - programming locked until next reset
// - only first pulse above threshold, below max
// - falling refresh resumes counting toward reload
// - short pulses only reload programmed value
// - refresh held past reload forces reset
// - inhibit high suppresses watchdog resets
`timescale 1ns/1ps
module watchdog_refresh_reset
  import watchdog_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_CYCLES,
  parameter int MAX_TICKS = MAX_TIMEOUT_TICKS,
  parameter int THRESHOLD_TICKS = PROGRAM_THRESHOLD_TICKS,
  parameter int PULSE_TICKS = RESET_PULSE_TICKS
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic watchdog_refresh_line_in,
  input wire logic watchdog_inhibit_line_in,
  output logic mcu_reset_n_out,
  output logic programmed_out
);
  localparam logic [TIMER_WIDTH-1:0] MAX_T = TIMER_WIDTH'(MAX_TICKS);
  localparam logic [TIMER_WIDTH-1:0] THR_T = TIMER_WIDTH'(THRESHOLD_TICKS);
  localparam logic [TIMER_WIDTH-1:0] PUL_T = TIMER_WIDTH'(PULSE_TICKS);

  logic refresh_sync;
  logic inhibit_sync;
  logic tick;

  sync_two_ff refresh_sync_u (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .async_in(watchdog_refresh_line_in),
    .sync_out(refresh_sync)
  );
  sync_two_ff inhibit_sync_u (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .async_in(watchdog_inhibit_line_in),
    .sync_out(inhibit_sync)
  );
  tick_divider #(.DIVIDE(TICK_DIVIDE)) tick_u (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .tick_out(tick)
  );

  wd_state_e state_reg;
  wd_state_e state_next;
  logic [TIMER_WIDTH-1:0] timer_reg;
  logic [TIMER_WIDTH-1:0] timer_next;
  logic [TIMER_WIDTH-1:0] reload_value_reg;
  logic [TIMER_WIDTH-1:0] reload_value_next;
  logic [TIMER_WIDTH-1:0] width_reg;
  logic [TIMER_WIDTH-1:0] width_next;
  logic [TIMER_WIDTH-1:0] pulse_reg;
  logic [TIMER_WIDTH-1:0] pulse_next;
  logic refresh_prev_reg;
  logic refresh_prev_next;
  logic locked_reg;
  logic locked_next;
  logic reset_n_next;
  logic rise;
  logic fall;
  logic fire;

  always_comb begin
    rise = refresh_sync & ~refresh_prev_reg;
    fall = ~refresh_sync & refresh_prev_reg;
    state_next = state_reg;
    timer_next = timer_reg;
    reload_value_next = reload_value_reg;
    width_next = width_reg;
    pulse_next = pulse_reg;
    refresh_prev_next = refresh_prev_reg;
    locked_next = locked_reg;
    reset_n_next = mcu_reset_n_out;
    fire = 1'b0;
    if (enable_in) begin
      refresh_prev_next = refresh_sync;
      unique case (state_reg)
        ST_RESET: begin
          // reset pulse output low; reload at maximum, timer cleared to zero
          reset_n_next = 1'b0;
          reload_value_next = MAX_T;
          timer_next = TIMER_ZERO;
          locked_next = 1'b0;
          width_next = TIMER_ZERO;
          if (tick) begin
            if (pulse_reg >= PUL_T - TIMER_ONE) begin
              state_next = ST_INIT;
              reset_n_next = 1'b1;
              pulse_next = TIMER_ZERO;
            end else begin
              pulse_next = pulse_reg + TIMER_ONE;
            end
          end
        end
        default: begin
          // ST_INIT before a programming pulse, ST_RUN after
          if (rise) begin
            timer_next = TIMER_ZERO;
            width_next = TIMER_ZERO;
          end else if (fall) begin
            timer_next = TIMER_ZERO;
            if (!locked_reg && width_reg > THR_T &&
                width_reg < MAX_T) begin
              reload_value_next = width_reg;
              locked_next = 1'b1;
              state_next = ST_RUN;
            end
          end else if (tick) begin
            if (refresh_sync) begin
              width_next = width_reg + TIMER_ONE;
              // held high past the reload time
              if (width_reg + TIMER_ONE >= reload_value_reg) begin
                fire = 1'b1;
                width_next = TIMER_ZERO;
              end
            end else begin
              timer_next = timer_reg + TIMER_ONE;
              if (timer_reg + TIMER_ONE >= reload_value_reg) begin
                fire = 1'b1;
                timer_next = TIMER_ZERO;
              end
            end
          end
          if (fire && !inhibit_sync) begin
            state_next = ST_RESET;
            reset_n_next = 1'b0;
            reload_value_next = MAX_T;
            timer_next = TIMER_ZERO;
            pulse_next = TIMER_ZERO;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= ST_RESET;
      timer_reg <= TIMER_ZERO;
      reload_value_reg <= MAX_T;
      width_reg <= TIMER_ZERO;
      pulse_reg <= TIMER_ZERO;
      refresh_prev_reg <= 1'b0;
      locked_reg <= 1'b0;
      mcu_reset_n_out <= 1'b0;
      programmed_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      reload_value_reg <= reload_value_next;
      width_reg <= width_next;
      pulse_reg <= pulse_next;
      refresh_prev_reg <= refresh_prev_next;
      locked_reg <= locked_next;
      mcu_reset_n_out <= reset_n_next;
      programmed_out <= locked_next;
    end
  end
endmodule

// file: common/watchdog_pkg.sv
// constants and types for the refresh watchdog
package watchdog_pkg;
  localparam int CLOCK_HZ = 100_000_000;
  // internal time base tick
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS * (CLOCK_HZ / 1_000_000)) / 1000;
  // timer figures in ticks of the time base
  localparam int MAX_TIMEOUT_TICKS = 100_000;
  localparam int PROGRAM_THRESHOLD_TICKS = 10_000;
  localparam int RESET_PULSE_TICKS = 5_000;
  localparam int TIMER_WIDTH = 20;
  localparam logic [TIMER_WIDTH-1:0] TIMER_ZERO = 20'h00000;
  localparam logic [TIMER_WIDTH-1:0] TIMER_ONE = 20'h00001;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b11
  } wd_state_e;
endpackage

// file: rtl/sync_two_ff.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module sync_two_ff (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic async_in,
  output logic sync_out
);
  logic first_reg;
  logic first_next;
  logic second_next;
  always_comb begin
    first_next = enable_in ? async_in : first_reg;
    second_next = enable_in ? first_reg : sync_out;
  end
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      first_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      first_reg <= first_next;
      sync_out <= second_next;
    end
  end
endmodule

// file: rtl/tick_divider.sv
// time base tick generator
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIVIDE = 100
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  output logic tick_out
);
  localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic tick_next;
  always_comb begin
    count_next = count_reg;
    tick_next = 1'b0;
    if (enable_in) begin
      if (count_reg == LAST) begin
        count_next = '0;
        tick_next = 1'b1;
      end else begin
        count_next = count_reg + CW'(1);
      end
    end else begin
      tick_next = tick_out;
    end
  end
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_out <= tick_next;
    end
  end
endmodule

// file: sim/wd_props.sv
// port assertions for the refresh watchdog
`timescale 1ns/1ps
module wd_props #(
  parameter int TICK_DIVIDE = 2,
  parameter int MAX_TICKS = 200,
  parameter int THRESHOLD_TICKS = 20
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic watchdog_refresh_line_in,
  input wire logic watchdog_inhibit_line_in,
  input wire logic mcu_reset_n_out,
  input wire logic programmed_out
);
  wire rn = mcu_reset_n_out;
  wire pg = programmed_out;
  int quiet_reg;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // clocks since refresh pin last moved
  always_ff @(posedge clock_in or posedge reset_in)
    if (reset_in)
      quiet_reg <= 0;
    else if (!rn || watchdog_inhibit_line_in)
      quiet_reg <= 0;
    else
      quiet_reg <= $changed(watchdog_refresh_line_in) ? 0 : quiet_reg + 1;
  AST_REL_LOW: assert property ($fell(reset_in) |-> !rn)
    else $error("reset out high at release");
  AST_PULSE: assert property ($fell(rn) |-> !rn [*8])
    else $error("reset pulse too short");
  AST_EARLY: assert property ($fell(rn) |->
    $past(quiet_reg) > THRESHOLD_TICKS * TICK_DIVIDE - 4)
    else $error("reset while refreshed");
  AST_LATE: assert property (quiet_reg < MAX_TICKS * TICK_DIVIDE + 16)
    else $error("no reset after quiet refresh");
  AST_INH: assert property (watchdog_inhibit_line_in [*4] |=> !$fell(rn))
    else $error("reset while inhibited");
  AST_PROG_RISE: assert property ($rose(pg) |->
    rn && !watchdog_refresh_line_in)
    else $error("programmed outside falling refresh");
  AST_PROG_HOLD: assert property (pg && rn |=> pg || !rn)
    else $error("programmed dropped");
  AST_PROG_CLR: assert property (!rn [*2] |-> !pg)
    else $error("programmed kept over reset");
endmodule
bind watchdog_refresh_reset wd_props #(.TICK_DIVIDE(TICK_DIVIDE),
  .MAX_TICKS(MAX_TICKS), .THRESHOLD_TICKS(THRESHOLD_TICKS)) i_wd_props (
  .clock_in, .reset_in, .enable_in, .watchdog_refresh_line_in,
  .watchdog_inhibit_line_in, .mcu_reset_n_out, .programmed_out);

// file: sim/mcu_model.sv
// host controller model sending periodic refresh pulses
`timescale 1ns/1ps
module mcu_model (
  input wire logic clock_in,
  input wire logic mcu_reset_n_in,
  input wire logic [31:0] high_in,
  input wire logic [31:0] low_in,
  output logic refresh_out
);
  int phase = 0;
  initial refresh_out = 1'h0;
  always @(posedge clock_in) begin
    #1;
    if (!mcu_reset_n_in || high_in == 0) begin
      refresh_out = 1'h0;
      phase = 0;
    end else begin
      refresh_out = phase < high_in;
      phase = (phase + 1) % (high_in + low_in);
    end
  end
endmodule

// file: sim/testbench.sv
// self-checking bench for the refresh watchdog
`timescale 1ns/1ps
module testbench;
  logic clock_in = 0, reset_in = 1, enable_in = 1, inh = 0, tb_rf = 0;
  logic mcu_rf, rn, pg;
  logic [31:0] seed = 32'h6800;
  int high = 0, low = 0, falls = 0, c, num_errors = 0, comparisons = 0;
  initial forever #5 clock_in = ~clock_in;
  always @(negedge rn) falls++;
  watchdog_refresh_reset #(.TICK_DIVIDE(2), .MAX_TICKS(200),
    .THRESHOLD_TICKS(20), .PULSE_TICKS(10)) i_watchdog_refresh_reset (
    .clock_in, .reset_in, .enable_in,
    .watchdog_refresh_line_in(mcu_rf | tb_rf),
    .watchdog_inhibit_line_in(inh), .mcu_reset_n_out(rn),
    .programmed_out(pg));
  mcu_model i_mcu_model (.clock_in, .mcu_reset_n_in(rn), .high_in(high),
    .low_in(low), .refresh_out(mcu_rf));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // two clocks a tick, plus sync and tick phase slack
  function automatic logic win(int ticks, int got);
    return got >= 2 * ticks - 4 && got <= 2 * ticks + 12;
  endfunction
  task automatic chk(string what, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_rn(logic v);
    c = 0;
    while (rn !== v) begin
      @(posedge clock_in);
      #1;
      c++;
      if (c > 3000) begin
        chk("wait_bound", 1'h1, 1'h0);
        complete_run();
      end
    end
  endtask
  // pulse then ten low clocks
  task automatic pulse(int w);
    tb_rf = 1;
    repeat (w) @(posedge clock_in);
    #1 tb_rf = 0;
    repeat (10) @(posedge clock_in);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    #1 reset_in = 0;
    wait_rn(1);
    chk("reset_pulse", 1'h1, win(10, c));
    falls = 0;
    repeat (6) begin
      seed = lfsr(seed);
      high = 4 + seed[2:0];
      low = 20 + seed[15:8] % 180;
      repeat (300) @(posedge clock_in);
      #1;
    end
    high = 0;
    chk("refreshed", 1'h1, falls == 0);
    chk("short_pulses", 1'h0, pg);
    pulse(6);
    wait_rn(0);
    chk("timeout_max", 1'h1, win(200 - 5, c));
    wait_rn(1);
    pulse(80);
    chk("programmed", 1'h1, pg);
    pulse(60);
    pulse(6);
    wait_rn(0);
    chk("timeout_prog", 1'h1, win(40 - 5, c));
    wait_rn(1);
    chk("prog_cleared", 1'h0, pg);
    tb_rf = 1;
    wait_rn(0);
    tb_rf = 0;
    chk("held_high", 1'h1, win(200, c));
    wait_rn(1);
    inh = 1;
    falls = 0;
    pulse(6);
    repeat (900) @(posedge clock_in);
    chk("inhibited", 1'h1, falls == 0);
    #1 inh = 0;
    pulse(80);
    chk("programmed_again", 1'h1, pg);
    reset_in = 1;
    repeat (3) @(posedge clock_in);
    #1 reset_in = 0;
    chk("por_prog_clear", 1'h0, pg);
    wait_rn(1);
    chk("por_pulse", 1'h1, win(10, c));
    complete_run();
  end
endmodule
